/* hdl/capture_pkg.sv */
// Functional notes
// (RULE1) event mode counts capture input 0 rising edges
// (RULE2) mode 11: window output edges load captures
// (RULE3) 16-bit counter, seen only through captures
// (RULE4) free-run counts prescaler clock, no match clear
// (RULE5) pulse-width mode: input 0 rise/fall captures
// (RULE6) capture 1 load raises interrupt 1 if enabled
// (RULE7) time-diff: input 0 rise loads capture 0
// (RULE8) time-diff: input 1 rise loads capture 1
// (RULE9) capture 0 load raises interrupt 0 if enabled
// (RULE10) window timer raises match interrupt for readout
// (RULE11) flip-flop toggles; control 00 toggle, 01 set, 10 clear
// (RULE12) captures hold until next edge; counter wraps
// (RULE13) inputs synchronized before edge detection
package capture_pkg;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [1:0] CPM_OFF = 2'h0;
	localparam logic [1:0] CPM_IN0_RISE_FALL = 2'h1;
	localparam logic [1:0] CPM_IN_RISE = 2'h2;
	localparam logic [1:0] CPM_WINDOW = 2'h3;
	localparam logic [1:0] FFC_TOGGLE = 2'h0;
	localparam logic [1:0] FFC_SET = 2'h1;
	localparam logic [1:0] FFC_CLEAR = 2'h2;
	localparam logic FF_RESET = 1'b0;
	typedef enum logic [1:0] {
		CLK_PRESCALER = 2'h0,
		CLK_EVENT = 2'h1
	} count_src_t;
endpackage : capture_pkg

/* hdl/timer_capture_measurement.sv */
`timescale 1ns/1ps
module timer_capture_measurement import capture_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic run_in,
	input wire logic event_mode_in,
	input wire logic prescale_tick_in,
	input wire logic [1:0] capture_mode_field_in,
	input wire logic capture_input_0_in,
	input wire logic capture_input_1_in,
	input wire logic window_timer_output_in,
	input wire logic window_timer_match_in,
	input wire logic int_en_0_in,
	input wire logic int_en_1_in,
	input wire logic ff_write_in,
	input wire logic [1:0] ff_control_in,
	input wire logic ff_toggle_cap0_en_in,
	input wire logic ff_toggle_cap1_en_in,
	input wire logic compare_match_in,
	input wire logic ff_toggle_match_en_in,
	output logic [CNT_W-1:0] capture_register_0_out,
	output logic [CNT_W-1:0] capture_register_1_out,
	output logic capture_interrupt_0_out,
	output logic capture_interrupt_1_out,
	output logic window_timer_match_interrupt_out,
	output logic timer_flip_flop_out
);
	// ------------------------------------------------
	// input synchronizers and edge detect
	// ------------------------------------------------
	logic [2:0] sync_a_ff;
	logic [2:0] sync_b_ff;
	logic [2:0] in_raw;
	logic [2:0] in_prev_ff;
	logic [2:0] rise;
	logic [2:0] fall;
	assign in_raw = {window_timer_output_in, capture_input_1_in, capture_input_0_in};
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			sync_a_ff <= 3'h0;
			sync_b_ff <= 3'h0;
			in_prev_ff <= 3'h0;
		end else begin
			sync_a_ff <= in_raw; // see (RULE13)
			sync_b_ff <= sync_a_ff;
			in_prev_ff <= sync_b_ff;
		end
	end
	assign rise = sync_b_ff & ~in_prev_ff; // see (RULE13)
	assign fall = ~sync_b_ff & in_prev_ff;
	// ------------------------------------------------
	// up counter
	// ------------------------------------------------
	logic [CNT_W-1:0] up_counter_ff;
	logic count_step;
	count_src_t src;
	assign src = event_mode_in ? CLK_EVENT : CLK_PRESCALER;
	always_comb begin
		case (src)
			CLK_EVENT: count_step = rise[0]; // see (RULE1)
			CLK_PRESCALER: count_step = prescale_tick_in; // see (RULE4)
			default: count_step = 1'b0;
		endcase
	end
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			up_counter_ff <= CNT_RESET;
		end else if (run_in && count_step) begin
			up_counter_ff <= up_counter_ff + CNT_ONE; // see (RULE3) (RULE12)
		end
	end
	// ------------------------------------------------
	// capture triggers
	// ------------------------------------------------
	logic load0;
	logic load1;
	always_comb begin
		case (capture_mode_field_in)
			CPM_IN0_RISE_FALL: begin
				load0 = rise[0]; // see (RULE5)
				load1 = fall[0];
			end
			CPM_IN_RISE: begin
				load0 = rise[0]; // see (RULE7)
				load1 = rise[1]; // see (RULE8)
			end
			CPM_WINDOW: begin
				load0 = rise[2]; // see (RULE2)
				load1 = fall[2];
			end
			default: begin
				load0 = 1'b0;
				load1 = 1'b0;
			end
		endcase
	end
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			capture_register_0_out <= CNT_RESET;
		end else if (load0) begin
			capture_register_0_out <= up_counter_ff; // see (RULE12)
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			capture_register_1_out <= CNT_RESET;
		end else if (load1) begin
			capture_register_1_out <= up_counter_ff; // see (RULE3)
		end
	end
	// ------------------------------------------------
	// interrupts
	// ------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			capture_interrupt_0_out <= 1'b0;
			capture_interrupt_1_out <= 1'b0;
			window_timer_match_interrupt_out <= 1'b0;
		end else begin
			capture_interrupt_0_out <= load0 && int_en_0_in; // see (RULE9)
			capture_interrupt_1_out <= load1 && int_en_1_in; // see (RULE6)
			window_timer_match_interrupt_out <= window_timer_match_in; // see (RULE10)
		end
	end
	// ------------------------------------------------
	// timer flip-flop
	// ------------------------------------------------
	logic ff_trig;
	assign ff_trig = (compare_match_in && ff_toggle_match_en_in) ||
		(load0 && ff_toggle_cap0_en_in) || (load1 && ff_toggle_cap1_en_in);
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			timer_flip_flop_out <= FF_RESET;
		end else if (ff_write_in && ff_control_in == FFC_SET) begin
			timer_flip_flop_out <= 1'b1; // see (RULE11)
		end else if (ff_write_in && ff_control_in == FFC_CLEAR) begin
			timer_flip_flop_out <= 1'b0; // see (RULE11)
		end else if ((ff_write_in && ff_control_in == FFC_TOGGLE) ^ ff_trig) begin
			timer_flip_flop_out <= ~timer_flip_flop_out; // see (RULE11)
		end
	end
endmodule : timer_capture_measurement

/* dv/cap_chk_properties.sv */
`timescale 1ns/1ps
module cap_chk import capture_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [1:0] capture_mode_field_in,
	input wire logic capture_input_0_in,
	input wire logic int_en_0_in,
	input wire logic int_en_1_in,
	input wire logic window_timer_match_in,
	input wire logic ff_write_in,
	input wire logic [1:0] ff_control_in,
	input wire logic capture_interrupt_0_out,
	input wire logic capture_interrupt_1_out,
	input wire logic window_timer_match_interrupt_out,
	input wire logic timer_flip_flop_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	wire m1 = capture_mode_field_in == CPM_IN0_RISE_FALL;
	wire p0 = capture_input_0_in;
	wire i0 = capture_interrupt_0_out;
	wire i1 = capture_interrupt_1_out;
	wire wr = ff_write_in;
	a_rise_int0: assert property (m1 && int_en_0_in && $rose(p0) |-> ##[2:4] i0) else $error("int0");
	a_fall_int1: assert property (m1 && int_en_1_in && $fell(p0) |-> ##[2:4] i1) else $error("int1");
	a_int_pulse: assert property (i0 |=> !i0) else $error("int0 long");
	a_off_quiet: assert property (capture_mode_field_in == CPM_OFF && $stable(capture_mode_field_in) |-> !i0 && !i1) else $error("off");
	a_int1_masked: assert property (!$past(int_en_1_in) |-> !i1) else $error("masked");
	a_match_copy: assert property (window_timer_match_in |=> window_timer_match_interrupt_out) else $error("match");
	a_ff_set: assert property (wr && ff_control_in == FFC_SET |=> timer_flip_flop_out) else $error("set");
	a_ff_clear: assert property (wr && ff_control_in == FFC_CLEAR |=> !timer_flip_flop_out) else $error("clr");
endmodule : cap_chk
bind timer_capture_measurement cap_chk u_chk (.*);

/* dv/pulse_src.sv */
`timescale 1ns/1ps
module pulse_src (
	input wire logic clk_sys_in,
	input wire logic go_in,
	input wire logic [7:0] width_in,
	output logic pulse_out
);
	logic [7:0] left_ff = 8'h00;
	always_ff @(posedge clk_sys_in) begin
		left_ff <= go_in ? width_in : left_ff - 8'(left_ff != 8'h00);
	end
	assign pulse_out = left_ff != 8'h00;
endmodule : pulse_src

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top import capture_pkg::*; ;
	logic clk_sys_in = 0, rst_in = 1, go = 0, in1 = 0, en = 0, wr = 0, mt = 0, p0, i1, ff, mo;
	logic ev = 0, win = 0, i0;
	logic [1:0] mode = 2'h0, ffc = 2'h0;
	logic [7:0] wid = 8'h00;
	logic [15:0] c0, c1;
	int n_errors = 0, checks_done = 0, cyc = 0;
	always #50 clk_sys_in = ~clk_sys_in;
	pulse_src src (.clk_sys_in, .go_in(go), .width_in(wid), .pulse_out(p0));
	timer_capture_measurement dut (.clk_sys_in, .rst_in, .run_in(en), .event_mode_in(ev),
		.prescale_tick_in(en), .capture_mode_field_in(mode), .capture_input_0_in(p0),
		.capture_input_1_in(in1), .window_timer_output_in(win), .window_timer_match_in(mt),
		.int_en_0_in(en), .int_en_1_in(en), .ff_write_in(wr), .ff_control_in(ffc),
		.ff_toggle_cap0_en_in(1'b0), .ff_toggle_cap1_en_in(1'b0), .compare_match_in(1'b0),
		.ff_toggle_match_en_in(1'b0), .capture_register_0_out(c0), .capture_register_1_out(c1),
		.capture_interrupt_0_out(i0), .capture_interrupt_1_out(i1),
		.window_timer_match_interrupt_out(mo), .timer_flip_flop_out(ff));
	task automatic chk(input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	task automatic t_width();
		mode <= CPM_IN0_RISE_FALL;
		{go, wid} <= {1'b1, 8'h09};
		@(posedge clk_sys_in) go <= 1'b0;
		for (int k = 0; k < 30 && i1 !== 1'b1; k++) @(posedge clk_sys_in);
		chk(c1 - c0, 16'h0009);
		chk({15'h0, i1}, 16'h0001);
		$display("width test done");
	endtask : t_width
	task automatic t_diff();
		mode <= CPM_IN_RISE;
		{go, wid} <= {1'b1, 8'h14};
		@(posedge clk_sys_in) go <= 1'b0;
		repeat (5) @(posedge clk_sys_in);
		in1 <= 1'b1;
		repeat (8) @(posedge clk_sys_in);
		chk(c1 - c0, 16'h0005);
		in1 <= 1'b0;
		$display("diff test done");
	endtask : t_diff
	task automatic t_ff();
		logic [1:0] c [3] = '{FFC_SET, FFC_CLEAR, FFC_TOGGLE};
		logic [2:0] e = 3'h5;
		for (int i = 0; i < 3; i++) begin
			{wr, ffc, mt} <= {1'b1, c[i], 1'b1};
			@(posedge clk_sys_in) {wr, mt} <= 2'h0;
			@(posedge clk_sys_in) chk({15'h0, ff}, {15'h0, e[2-i]});
			chk({15'h0, mo}, 16'h0001);
		end
		$display("flip-flop test done");
	endtask : t_ff
	task automatic t_event();
		mode <= CPM_WINDOW;
		ev <= 1'b1;
		win <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		chk({15'h0, i0}, 16'h0001);
		repeat (3) begin
			{go, wid} <= {1'b1, 8'h02};
			@(posedge clk_sys_in) go <= 1'b0;
			repeat (3) @(posedge clk_sys_in);
		end
		win <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		chk(c1 - c0, 16'h0003);
		chk({15'h0, i1}, 16'h0001);
		ev <= 1'b0;
		$display("event window test done");
	endtask : t_event
	initial begin
		repeat (20) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		en <= 1'b1;
		@(posedge clk_sys_in);
		t_width();
		t_diff();
		t_ff();
		t_event();
		results();
	end
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 500) begin
			n_errors++;
			results();
		end
	end
endmodule : tb_top
